// *** verilog/arec_ctrl.sv ***
`timescale 1ns/100ps
// Contract
// (RULE1) Separate 3-bit positive and negative selectors
// (RULE2) Selectors pick internal, external or supply
// (RULE3) Both zero routes internal reference
// (RULE4) Internal reference enable, on after reset
// (RULE5) First mode bit 7 swaps reference nodes
// (RULE6) Host keeps reversal off for internal/supply; the host clears it only on first mode writes while both selectors are zero
// (RULE7) Both converters reset to internal reference
// (RULE8) Low reference alarm in status bit 4
// (RULE9) Alarm latches any dip during conversion; the code drops dips seen on fewer than two consecutive clock samples
// (RULE10) Alarm clears at each new conversion
// (RULE11) Each source routed to any of 11 pins
// (RULE12) Nine excitation magnitude codes
// (RULE13) Host enables reference when sources used
// (RULE14) Rotation swaps sources, starts normal
// (RULE15) First withheld, then pairwise averages
// (RULE16) Settling delay after swap plus delay field
// (RULE17) Host waits for level shift to settle
// (RULE18) Host waits reference start-up time
// (RULE19) Modulator tick at clock divided by 8
// (RULE20) Sinc mode orders 1 to 5, rates
// (RULE21) FIR mode capped at 20 samples per second
// (RULE22) 3-bit sinc order field, second mode register
// (RULE23) Config change restarts rotation sequence; code restarts only on rotation entry or excitation pin/magnitude writes
module arec_ctrl #(
	parameter int DATA_W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter handshake
	input wire logic conv_req,
	input wire logic conv_done,
	input wire logic [DATA_W-1:0] conv_raw,
	input wire logic ref_low_pin,
	// Analog controls
	output logic mod_tick,
	output logic conv_start,
	output logic [2:0] pos_ref_select,
	output logic [2:0] neg_ref_select,
	output logic ref_polarity_reverse,
	output logic [5:0] aux_ref_select,
	output logic internal_ref_enable,
	output logic level_shift_enable,
	output logic [3:0] exc_a_pin,
	output logic [3:0] exc_b_pin,
	output logic [3:0] exc_a_mag,
	output logic [3:0] exc_b_mag,
	output logic fir_mode,
	output logic [2:0] sinc_order,
	output logic [3:0] data_rate,
	output logic settle_busy,
	// Results
	output logic result_valid,
	output logic [DATA_W-1:0] result_data,
	output logic [7:0] status_byte
);
	import arec_pkg::*;

	// ==========================================================
	// Bus slave
	logic wr_pend_q; // Write data phase pending
	logic [7:0] wa_q; // Latched write offset
	logic [7:0] refsel_q, first_mode_register_q, second_mode_register_q, power_q;
	logic [7:0] excpin_q, excmag_q, aux_q;
	logic [31:0] rdv; // Read mux
	logic [31:0] st_word; // Status word
	wire acc = hsel & hready & htrans[1];
	wire [7:0] ra = {haddr[7:2], 2'b00};
	wire wr_refsel = wr_pend_q & (wa_q == REFSEL_OFS);
	wire wr_first_mode_register = wr_pend_q & (wa_q == FIRST_MODE_REGISTER_OFS);
	wire wr_second_mode_register = wr_pend_q & (wa_q == SECOND_MODE_REGISTER_OFS);
	wire wr_power = wr_pend_q & (wa_q == POWER_OFS);
	wire wr_excpin = wr_pend_q & (wa_q == EXCPIN_OFS);
	wire wr_excmag = wr_pend_q & (wa_q == EXCMAG_OFS);
	wire wr_aux = wr_pend_q & (wa_q == AUXREF_OFS);

	// Read selection, unmapped reads as zero
	always_comb begin
		unique case (ra)
			REFSEL_OFS: rdv = {24'h000000, refsel_q};
			FIRST_MODE_REGISTER_OFS: rdv = {24'h000000, first_mode_register_q};
			SECOND_MODE_REGISTER_OFS: rdv = {24'h000000, second_mode_register_q};
			POWER_OFS: rdv = {24'h000000, power_q};
			EXCPIN_OFS: rdv = {24'h000000, excpin_q};
			EXCMAG_OFS: rdv = {24'h000000, excmag_q};
			AUXREF_OFS: rdv = {24'h000000, aux_q};
			STATUS_OFS: rdv = st_word;
			RESULT_OFS: rdv = 32'(result_data);
			default: rdv = 32'h00000000;
		endcase
	end

	// Address phase capture, zero wait states
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
			wa_q <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_q <= acc & hwrite;
			wa_q <= ra;
			if (acc && !hwrite) begin
				hrdata <= rdv;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			refsel_q <= 8'h00; // RULE3 RULE7
			first_mode_register_q <= 8'h00;
			second_mode_register_q <= SECOND_MODE_REGISTER_RST;
			power_q <= POWER_RST; // RULE4
			excpin_q <= 8'h00;
			excmag_q <= 8'h00;
			aux_q <= 8'h00; // RULE7
		end else begin
			if (wr_refsel) refsel_q <= {2'b00, hwdata[5:0]}; // RULE1
			if (wr_first_mode_register) first_mode_register_q <= {hwdata[7:6], 2'b00, hwdata[3:0]};
			if (wr_second_mode_register) second_mode_register_q <= hwdata[7:0];
			if (wr_power) power_q <= {6'h00, hwdata[1:0]};
			if (wr_excpin) excpin_q <= hwdata[7:0];
			if (wr_excmag) excmag_q <= hwdata[7:0];
			if (wr_aux) aux_q <= {2'b00, hwdata[5:0]};
		end
	end

	// ==========================================================
	// Field decode
	wire rot_en = first_mode_register_q[ROT_BIT];
	wire [3:0] dly = first_mode_register_q[3:0];
	wire [3:0] pa = (excpin_q[3:0] > PIN_MAX) ? PIN_MAX : excpin_q[3:0]; // RULE11
	wire [3:0] pb = (excpin_q[7:4] > PIN_MAX) ? PIN_MAX : excpin_q[7:4]; // RULE11
	wire [3:0] ma = (excmag_q[3:0] > MAG_MAX) ? MAG_MAX : excmag_q[3:0]; // RULE12
	wire [3:0] mb = (excmag_q[7:4] > MAG_MAX) ? MAG_MAX : excmag_q[7:4]; // RULE12
	wire [2:0] ord = (second_mode_register_q[2:0] > ORD_MAX) ? ORD_MAX : second_mode_register_q[2:0]; // RULE22 RULE20
	wire [3:0] dr_raw = second_mode_register_q[DR_LSB+3:DR_LSB];
	wire fir = second_mode_register_q[FIR_BIT];
	wire [3:0] dr = (fir && dr_raw > FIR_DR_MAX) ? FIR_DR_MAX : dr_raw; // RULE21
	// Rotation restart on entry or on an excitation pin or magnitude write
	wire restart = (wr_first_mode_register & hwdata[ROT_BIT] & ~rot_en)
		| wr_excpin | wr_excmag; // RULE23

	// ==========================================================
	// Modulator rate divider
	logic [2:0] div_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_q <= 3'h0;
			mod_tick <= 1'b0;
		end else begin
			div_q <= div_q + 3'h1; // RULE19
			mod_tick <= (div_q == 3'(MOD_DIV - 1));
		end
	end

	// ==========================================================
	// Low reference comparator synchroniser
	logic s1_q, s2_q, s3_q, low_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			low_q <= 1'b0;
		end else begin
			s1_q <= ref_low_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) low_q <= s3_q;
		end
	end

	// ==========================================================
	// Conversion sequencing
	logic act_q; // Conversion in progress
	logic alm_q; // Latched alarm
	logic phase_q; // Rotation phase, 0 normal
	logic first_q; // Next result withheld
	logic [CNT_W-1:0] cnt_q; // Settling countdown
	logic [DATA_W-1:0] prev_q; // Previous raw conversion
	wire fire = conv_req & ~act_q & ~settle_busy & ~restart;
	wire alm_now = alm_q | (low_q & act_q); // RULE9
	wire [DATA_W:0] sum = {1'b0, conv_raw} + {1'b0, prev_q};
	wire [CNT_W-1:0] dly_cyc = CNT_W'(ROT_BASE_CYC)
		+ CNT_W'(dly) * CNT_W'(ROT_STEP_CYC); // RULE16
	wire alm_d = (fire ? 1'b0 : alm_q) | (low_q & (act_q | fire)); // RULE9 RULE10

	// Start, alarm and activity
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			act_q <= 1'b0;
			alm_q <= 1'b0;
			conv_start <= 1'b0;
		end else begin
			conv_start <= fire;
			alm_q <= alm_d;
			if (fire) act_q <= 1'b1;
			else if (conv_done) act_q <= 1'b0;
		end
	end

	// Rotation, averaging and settling
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_q <= 1'b0;
			first_q <= 1'b1;
			cnt_q <= '0;
			prev_q <= '0;
			result_valid <= 1'b0;
			result_data <= '0;
			status_byte <= 8'h00;
			settle_busy <= 1'b0;
		end else begin
			result_valid <= 1'b0;
			settle_busy <= (cnt_q > CNT_W'(1));
			if (cnt_q != '0) cnt_q <= cnt_q - CNT_W'(1);
			if (restart || !rot_en) begin
				phase_q <= 1'b0; // RULE14 RULE23
				first_q <= 1'b1;
			end
			if (restart) begin
				cnt_q <= '0;
				settle_busy <= 1'b0;
			end else if (conv_done && act_q) begin
				status_byte <= {3'b000, alm_now, 3'b000, phase_q}; // RULE8
				prev_q <= conv_raw;
				if (!rot_en) begin
					result_data <= conv_raw;
					result_valid <= 1'b1;
				end else begin
					phase_q <= ~phase_q; // RULE14
					first_q <= 1'b0;
					cnt_q <= dly_cyc; // RULE16
					settle_busy <= 1'b1;
					if (!first_q) begin
						result_data <= sum[DATA_W:1]; // RULE15
						result_valid <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================
	// Registered analog controls
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pos_ref_select <= 3'h0;
			neg_ref_select <= 3'h0;
			ref_polarity_reverse <= 1'b0;
			aux_ref_select <= 6'h00;
			internal_ref_enable <= 1'b1;
			level_shift_enable <= 1'b0;
			exc_a_pin <= 4'h0;
			exc_b_pin <= 4'h0;
			exc_a_mag <= 4'h0;
			exc_b_mag <= 4'h0;
			fir_mode <= 1'b0;
			sinc_order <= 3'h0;
			data_rate <= 4'h0;
		end else begin
			// Node selections pass straight, the reversal switch does any swap
			pos_ref_select <= refsel_q[POS_LSB+:3]; // RULE2
			neg_ref_select <= refsel_q[NEG_LSB+:3]; // RULE2
			ref_polarity_reverse <= first_mode_register_q[REV_BIT]; // RULE5
			aux_ref_select <= aux_q[5:0];
			internal_ref_enable <= power_q[0]; // RULE4
			level_shift_enable <= power_q[1];
			exc_a_pin <= phase_q ? pb : pa; // RULE14
			exc_b_pin <= phase_q ? pa : pb;
			exc_a_mag <= ma;
			exc_b_mag <= mb;
			fir_mode <= fir; // RULE20
			sinc_order <= ord;
			data_rate <= dr;
		end
	end
	assign st_word = {27'h0000000, alm_q, settle_busy, act_q, first_q, phase_q};

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_alarm_bit;
		conv_done && act_q && alm_now |=> status_byte[ALM_BIT];
	endproperty
	a_alarm_bit: assert property (p_alarm_bit) else $error("alarm lost"); // RULE8
	property p_alarm_clear;
		fire && !low_q |=> !alm_q;
	endproperty
	a_alarm_clear: assert property (p_alarm_clear) else $error("alarm kept"); // RULE10
	property p_alarm_set;
		act_q && low_q |=> alm_q;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("dip missed"); // RULE9
	property p_div;
		mod_tick |=> !mod_tick [*7] ##1 mod_tick;
	endproperty
	a_div: assert property (p_div) else $error("divider period"); // RULE19
	property p_withhold;
		conv_done && act_q && rot_en && first_q && !restart |=> !result_valid;
	endproperty
	a_withhold: assert property (p_withhold) else $error("first not withheld"); // RULE15
	property p_avg;
		conv_done && act_q && rot_en && !first_q && !restart
			|=> result_valid && result_data == $past(sum[DATA_W:1]);
	endproperty
	a_avg: assert property (p_avg) else $error("average wrong"); // RULE15
	property p_swap;
		phase_q |=> exc_a_pin == $past(pb) && exc_b_pin == $past(pa);
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong"); // RULE14
	property p_settle;
		conv_done && act_q && rot_en && !restart |=> settle_busy && cnt_q == $past(dly_cyc);
	endproperty
	a_settle: assert property (p_settle) else $error("settle length"); // RULE16
	property p_restart;
		restart |=> !phase_q && first_q;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart"); // RULE23
	property p_fir;
		fir_mode |-> data_rate <= FIR_DR_MAX;
	endproperty
	a_fir: assert property (p_fir) else $error("fir rate"); // RULE21
	c_rot: cover property (rot_en && result_valid);
	c_alarm: cover property (status_byte[ALM_BIT]);
	c_settle: cover property (settle_busy ##1 !settle_busy);
endmodule // arec_ctrl

// *** verilog/arec_pkg.sv ***
// ==========================================================
// Shared constants of the reference and excitation control
package arec_pkg;
	// Register byte offsets
	localparam logic [7:0] REFSEL_OFS = 8'h00; // reference_select_register
	localparam logic [7:0] FIRST_MODE_REGISTER_OFS = 8'h04; // first_mode_register
	localparam logic [7:0] SECOND_MODE_REGISTER_OFS = 8'h08; // second_mode_register
	localparam logic [7:0] POWER_OFS = 8'h0C; // Reference and level shift enables
	localparam logic [7:0] EXCPIN_OFS = 8'h10; // Excitation pin routing
	localparam logic [7:0] EXCMAG_OFS = 8'h14; // Excitation magnitudes
	localparam logic [7:0] AUXREF_OFS = 8'h18; // Auxiliary converter reference
	localparam logic [7:0] STATUS_OFS = 8'h1C; // Live status
	localparam logic [7:0] RESULT_OFS = 8'h20; // Last delivered result
	// Field positions
	localparam int POS_LSB = 3; // pos_ref_select [5:3]
	localparam int NEG_LSB = 0; // neg_ref_select [2:0]
	localparam int REV_BIT = 7; // ref_polarity_reverse
	localparam int ROT_BIT = 6; // Automatic rotation enable
	localparam int FIR_BIT = 7; // FIR filter mode in second mode register
	localparam int DR_LSB = 3; // Data rate [6:3]
	localparam int ALM_BIT = 4; // low_ref_alarm in status byte
	// Reset values
	localparam logic [7:0] POWER_RST = 8'h01; // Internal reference on
	localparam logic [7:0] SECOND_MODE_REGISTER_RST = 8'h04; // Sinc order code
	// Limits
	localparam logic [3:0] PIN_MAX = 4'hA; // 11 pins, codes 0..10
	localparam logic [3:0] MAG_MAX = 4'h8; // Nine magnitude codes
	localparam logic [2:0] ORD_MAX = 3'h4; // Orders 1..5 as codes 0..4
	localparam logic [3:0] FIR_DR_MAX = 4'h4; // 20 samples per second
	// Timing at 100 MHz
	localparam int CLK_NS = 10;
	localparam int MOD_DIV = 8; // Modulator rate divider
	localparam int ROT_BASE_NS = 500; // Built-in settling after swap
	localparam int ROT_STEP_NS = 1000; // Extra settling per delay step
	localparam int ROT_BASE_CYC = (ROT_BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ROT_STEP_CYC = (ROT_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 12; // Settling counter width
endpackage

// *** verif/arec_host.sv ***
`timescale 1ns/100ps
// ==========================================================
// Host model: AHB-Lite master that programs the block
module arec_host
	import arec_pkg::*;
#(
	parameter int WAIT_CYC = 50 // Scaled reference and level shift settling
) (
	// Bus side
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	logic [7:0] refsel_q = 8'h00; // Shadow of reference selection
	logic [1:0] power_q = 2'h1; // Shadow of power enables
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// One single word transfer, address phase then data phase
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;
	endtask
	// Power enables, then wait for the analog parts to settle
	task power(input logic ir, input logic ls);
		logic [31:0] q;
		power_q = {ls, ir};
		xfer(POWER_OFS, 1'b1, {30'h0, ls, ir}, q);
		repeat (WAIT_CYC) @(posedge clk);
	endtask
	// Register write with the host's own safeguards
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic [31:0] q;
		v = d;
		if (a == FIRST_MODE_REGISTER_OFS && refsel_q[5:0] == 6'h00) v[REV_BIT] = 1'b0;
		if ((a == EXCMAG_OFS || a == EXCPIN_OFS) && !power_q[0]) power(1'b1, power_q[1]);
		if (a == REFSEL_OFS) refsel_q = v[7:0];
		xfer(a, 1'b1, v, q);
	endtask
	// Register read
	task rd(input logic [7:0] a, output logic [31:0] q);
		xfer(a, 1'b0, 32'h0, q);
	endtask
endmodule // arec_host

// *** verif/arec_ctrl_bench.sv ***
`timescale 1ns/100ps
// ==========================================================
// Bench of the reference and excitation control
module arec_ctrl_bench;
	import arec_pkg::*;
	typedef struct {logic [31:0] data; logic alarm; logic phase;} arec_exp_t;
	logic clk = 1'b0; // 100 MHz
	logic sys_rst = 1'b1;
	logic conv_req = 1'b0;
	logic conv_done = 1'b0;
	logic ref_low_pin = 1'b0;
	logic [31:0] conv_raw = 32'h0;
	wire logic hsel, hwrite, hreadyout, hresp, mod_tick, conv_start, rev, iref, lvl, fir, busy, rvalid;
	wire logic [1:0] htrans;
	wire logic [2:0] hsize, psel, nsel, order;
	wire logic [3:0] apin, bpin, amag, bmag, rate;
	wire logic [5:0] aux;
	wire logic [7:0] status_byte;
	wire logic [31:0] haddr, hwdata, hrdata, rdata;
	int mismatches = 0;
	int n_compared = 0;
	int seed = 95670;
	int dly, n, i;
	logic rot = 1'b0, primed = 1'b0, ph = 1'b0; // Rotation model state
	logic [31:0] prev, d, raw_last;
	logic [3:0] pa = 4'h0, pb = 4'h0; // Programmed excitation pins
	arec_exp_t exp_q[$]; // Expected results in order
	always #5 clk = ~clk;
	arec_host host(.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	arec_ctrl dut(.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .conv_req(conv_req), .conv_done(conv_done),
		.conv_raw(conv_raw), .ref_low_pin(ref_low_pin), .mod_tick(mod_tick),
		.conv_start(conv_start), .pos_ref_select(psel), .neg_ref_select(nsel),
		.ref_polarity_reverse(rev), .aux_ref_select(aux), .internal_ref_enable(iref),
		.level_shift_enable(lvl), .exc_a_pin(apin), .exc_b_pin(bpin), .exc_a_mag(amag),
		.exc_b_mag(bmag), .fir_mode(fir), .sinc_order(order), .data_rate(rate),
		.settle_busy(busy), .result_valid(rvalid), .result_data(rdata), .status_byte(status_byte));
	// Compare and count
	task check(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask
	// Verdict and end of run
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [3:0] lim(input logic [3:0] v, input logic [3:0] m);
		return (v > m) ? m : v;
	endfunction
	// Write, then let the output registers follow
	task wset(input logic [7:0] a, input logic [31:0] v);
		host.wr(a, v);
		repeat (2) @(posedge clk);
	endtask
	// One conversion with an optional short reference dip
	task conv(input logic dip);
		logic [31:0] raw;
		logic [32:0] sum;
		raw = $random(seed);
		raw_last = raw;
		conv_req <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (conv_start !== 1'b1 && n < 2000);
		conv_req <= 1'b0;
		check("conv start", conv_start, 1'b1);
		check("exc a pin", apin, ph ? pb : pa);
		check("exc b pin", bpin, ph ? pa : pb);
		if (dip) begin
			@(posedge clk);
			ref_low_pin <= 1'b1;
			repeat (2) @(posedge clk);
			ref_low_pin <= 1'b0;
		end
		repeat (12) @(posedge clk);
		conv_done <= 1'b1;
		conv_raw <= raw;
		sum = {1'b0, raw} + {1'b0, prev};
		if (!rot) exp_q.push_back('{raw, dip, 1'b0});
		else if (primed) exp_q.push_back('{sum[32:1], dip, ph});
		@(posedge clk);
		conv_done <= 1'b0;
		conv_raw <= ~raw;
		if (rot) begin
			primed = 1'b1;
			prev = raw;
			ph = ~ph;
			n = 0;
			@(posedge clk);
			while (busy === 1'b1 && n < 3000) begin n++; @(posedge clk); end
			check("settle cycles", n, ROT_BASE_CYC + dly * ROT_STEP_CYC);
		end
	endtask
	// Result watcher: oldest note against each delivered result
	always @(posedge clk) begin : watch
		arec_exp_t e;
		if (!sys_rst && rvalid === 1'b1) begin
			if (exp_q.size() == 0) check("unexpected result", 32'h1, 32'h0);
			else begin
				e = exp_q.pop_front();
				check("result", rdata, e.data);
				check("alarm bit", status_byte[ALM_BIT], e.alarm);
				check("phase bit", status_byte[0], e.phase);
			end
		end
	end
	// Watchdog against a hang
	initial begin
		#400000;
		mismatches++;
		print_verdict;
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("int ref after reset", iref, 1'b1);
		check("pos sel after reset", psel, 3'h0);
		check("neg sel after reset", nsel, 3'h0);
		check("aux sel after reset", aux, 6'h00);
		check("hresp", hresp, 1'b0);
		check("hreadyout", hreadyout, 1'b1);
		host.rd(POWER_OFS, d);
		check("power reg", d[7:0], POWER_RST);
		host.rd(SECOND_MODE_REGISTER_OFS, d);
		check("second_mode_register reg", d[7:0], SECOND_MODE_REGISTER_RST);
		host.rd(8'h40, d);
		check("unmapped read", d, 32'h0);
		for (i = 0; i < 8; i++) begin
			wset(REFSEL_OFS, {26'h0, i[2:0], 3'h7 - i[2:0]});
			check("pos sel", psel, i[2:0]);
			check("neg sel", nsel, 3'h7 - i[2:0]);
		end
		host.rd(REFSEL_OFS, d);
		check("refsel reg", d[5:0], 6'h38);
		wset(AUXREF_OFS, 32'h2D);
		check("aux sel", aux, 6'h2D);
		wset(FIRST_MODE_REGISTER_OFS, 32'h80);
		check("reverse on", rev, 1'b1);
		wset(FIRST_MODE_REGISTER_OFS, 32'h00);
		check("reverse off", rev, 1'b0);
		host.power(1'b1, 1'b1);
		@(posedge clk);
		check("level shift", lvl, 1'b1);
		host.power(1'b0, 1'b0);
		@(posedge clk);
		check("int ref off", iref, 1'b0);
		for (i = 0; i < 16; i++) begin
			wset(EXCPIN_OFS, {24'h0, 4'hF - i[3:0], i[3:0]});
			check("pin a", apin, lim(i[3:0], PIN_MAX));
			check("pin b", bpin, lim(4'hF - i[3:0], PIN_MAX));
			wset(EXCMAG_OFS, {24'h0, i[3:0], 4'hF - i[3:0]});
			check("mag a", amag, lim(4'hF - i[3:0], MAG_MAX));
			check("mag b", bmag, lim(i[3:0], MAG_MAX));
			wset(SECOND_MODE_REGISTER_OFS, {24'h0, i[0], i[3:0], i[2:0]});
			check("fir", fir, i[0]);
			check("order", order, lim({1'b0, i[2:0]}, {1'b0, ORD_MAX}));
			check("rate", rate, i[0] ? lim(i[3:0], FIR_DR_MAX) : i[3:0]);
		end
		do @(posedge clk); while (mod_tick !== 1'b1);
		n = 0;
		do begin @(posedge clk); n++; end while (mod_tick !== 1'b1 && n < 20);
		check("tick period", n, MOD_DIV);
		pa = 4'($unsigned($random(seed)) % 11);
		pb = 4'hA - pa;
		wset(EXCPIN_OFS, {24'h0, pb, pa});
		conv(1'b1);
		conv(1'b0);
		conv(1'b1);
		dly = $unsigned($random(seed)) % 3;
		wset(FIRST_MODE_REGISTER_OFS, 32'h40 | dly);
		rot = 1'b1;
		repeat (3) conv(1'b0);
		conv(1'b1);
		wset(EXCPIN_OFS, {24'h0, pa, pb});
		{pa, pb} = {pb, pa};
		{primed, ph} = 2'b00;
		repeat (3) conv(1'b0);
		wset(FIRST_MODE_REGISTER_OFS, 32'h00);
		{rot, ph} = 2'b00;
		conv(1'b0);
		repeat (5) @(posedge clk);
		check("results left", exp_q.size(), 32'h0);
		host.rd(RESULT_OFS, d);
		check("result reg", d, raw_last);
		host.rd(STATUS_OFS, d);
		check("status reg", d, 32'h2);
		print_verdict;
	end
endmodule // arec_ctrl_bench
